//--- logic/alu_slice_pkg.sv
package alu_slice_pkg;
    // datapath shape
    localparam int DataWidth = 16;
    localparam int FnWidth = 3;
    localparam logic [15:0] AllZero = 16'h0000;
    localparam logic [15:0] AllOnes = 16'hFFFF;

    // function select codes
    localparam logic [2:0] FnClear = 3'h0;
    localparam logic [2:0] FnNotAPlusB = 3'h1;
    localparam logic [2:0] FnAPlusNotB = 3'h2;
    localparam logic [2:0] FnAdd = 3'h3;
    localparam logic [2:0] FnXor = 3'h4;
    localparam logic [2:0] FnOr = 3'h5;
    localparam logic [2:0] FnAnd = 3'h6;
    localparam logic [2:0] FnPreset = 3'h7;

    // register bus
    localparam int AddrWidth = 8;
    localparam logic [7:0] CtrlAddr = 8'h00;
    localparam logic [7:0] FlagsAddr = 8'h04;
    localparam logic [7:0] ResultAddr = 8'h08;
    localparam logic [7:0] IrqStatusAddr = 8'h0C;
    localparam logic [7:0] IrqMaskAddr = 8'h10;
    localparam logic [1:0] RespOkay = 2'h0;
    localparam logic [1:0] RespSlvErr = 2'h2;

    // control register fields
    localparam int CtrlLoadEnBit = 0;
    localparam logic CtrlLoadEnReset = 1'b1;

    // event bits, shared by status, mask and live flags
    localparam int EventCount = 3;
    localparam int EvOverflowBit = 0;
    localparam int EvCarryBit = 1;
    localparam int EvZeroBit = 2;
    localparam logic [2:0] IrqStatusReset = 3'h0;
    localparam logic [2:0] IrqMaskReset = 3'h0;
    localparam logic [15:0] ResultReset = 16'h0000;
endpackage

//--- logic/operand_mux.sv
`timescale 1ns/1ps
`default_nettype none
module operand_mux (
    input wire logic [15:0] operandA, // a operand from datapath
    input wire logic [15:0] operandB, // b operand from datapath
    input wire logic [15:0] feedback, // registered result
    input wire logic operand_a_select, // a side select
    input wire logic operand_b_select, // b side select
    output logic [15:0] aluA, // word on alu a input
    output logic [15:0] aluB // word on alu b input
);
    // select table, b select first: 00 fb/a, 01 0/a, 10 b/0, 11 b/a
    always_comb begin
        case ({operand_b_select, operand_a_select})
            2'b00: begin
                aluB = feedback;
                aluA = operandA;
            end
            2'b01: begin
                aluB = alu_slice_pkg::AllZero;
                aluA = operandA;
            end
            2'b10: begin
                aluB = operandB;
                aluA = alu_slice_pkg::AllZero;
            end
            default: begin
                aluB = operandB;
                aluA = operandA;
            end
        endcase
    end
endmodule
`default_nettype wire

//--- logic/carry_lookahead.sv
`timescale 1ns/1ps
`default_nettype none
module carry_lookahead (
    input wire logic [15:0] opA, // effective a bits
    input wire logic [15:0] opB, // effective b bits
    input wire logic carry_in, // carry into bit 0
    output logic [15:0] carries, // carry into each bit
    output logic carry_out, // ripple carry out
    output logic overflow_flag, // two's complement overflow
    output logic group_generate_n, // group generate, active low
    output logic group_propagate_n // group propagate, active low
);
    logic [15:0] bitGen;
    logic [15:0] bitProp;
    logic [15:0] cumGen;
    logic [15:0] cumProp;

    // per-bit terms and cumulative chain
    assign cumGen[0] = bitGen[0];
    assign cumProp[0] = bitProp[0];
    assign carries[0] = carry_in;
    genvar i;
    generate
        for (i = 0; i < alu_slice_pkg::DataWidth; i++) begin : gBit
            assign bitGen[i] = opA[i] & opB[i];
            assign bitProp[i] = opA[i] | opB[i];
            if (i > 0) begin : gChain
                assign cumProp[i] = bitProp[i] & cumProp[i-1];
                assign cumGen[i] = bitGen[i] | (bitProp[i] & cumGen[i-1]);
                assign carries[i] = cumGen[i-1] | (cumProp[i-1] & carries[i-1]);
            end
        end
    endgenerate

    // group outputs for cascading slices
    assign group_generate_n = ~cumGen[15];
    assign group_propagate_n = ~cumProp[15];
    assign carry_out = cumGen[15] | (cumProp[15] & carries[15]);
    assign overflow_flag = carries[15] ^ carry_out;
endmodule
`default_nettype wire

//--- logic/alu_operand_select_and_status.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - two operand muxes sit directly before the alu inputs, steered by both selects
// - both selects low: result register feeds b, a operand feeds a
// - feedback always comes from the result register, whatever output_bypass says
// - bit generate is the and of the two operand bits, bits 0 to 15
// - bit propagate is the or of the two operand bits, bits 0 to 15
// - cumulative propagate chains bit propagates upward with and
// - cumulative generate is bit generate or propagate and previous generate
// - carry i comes from previous generate, propagate and carry; carry 0 is carry_in
// - group outputs are inverted bit-15 cumulative generate and propagate
// - carry_out is g15 or p15 and carry 15
// - overflow_flag is carry 15 xor carry_out
// - select encoding: 00 fb/a, 01 zero/a, 10 b/zero, 11 b/a
// - carry, overflow and group outputs matter only for the three arithmetic functions; zero status holds for every function
// - subtract forms evaluate carries with a or b bits complemented
// - zero status is high exactly when all sixteen alu result bits are low
module alu_operand_select_and_status (
    input wire logic sys_clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [15:0] operandA, // a operand
    input wire logic [15:0] operandB, // b operand
    input wire logic operand_a_select, // a side select
    input wire logic operand_b_select, // b side select
    input wire logic [2:0] function_select, // alu function code
    input wire logic carry_in, // carry into bit 0
    input wire logic resultLoad, // load result register this edge
    input wire logic output_bypass, // drive alu result straight out
    output logic [15:0] result, // result word
    output logic zeroFlag, // alu result all zero
    output logic overflow_flag, // two's complement overflow
    output logic carry_out, // ripple carry out
    output logic group_generate_n, // group generate, active low
    output logic group_propagate_n, // group propagate, active low
    output logic irq, // level interrupt
    input wire logic [7:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [7:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready // read data ready
);
    logic [15:0] resultReg;
    logic [15:0] aluA;
    logic [15:0] aluB;
    logic [15:0] effA;
    logic [15:0] effB;
    logic [15:0] carries;
    logic [15:0] aluResult;
    logic isArith;
    logic loadEnable;
    logic loadNow;
    logic [2:0] liveFlags;
    logic [2:0] irqStatus;
    logic [2:0] irqMask;
    logic [2:0] eventSet;
    logic [7:0] awAddrHeld;
    logic awHeld;
    logic [31:0] wDataHeld;
    logic [3:0] wStrbHeld;
    logic wHeld;
    logic doWrite;
    logic doRead;
    logic statusReadClear;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // operand selection ahead of the alu
    operand_mux uMux (
        .operandA(operandA),
        .operandB(operandB),
        .feedback(resultReg),
        .operand_a_select(operand_a_select),
        .operand_b_select(operand_b_select),
        .aluA(aluA),
        .aluB(aluB)
    );

    // subtract forms complement one side before the carry chain
    assign effA = (function_select == alu_slice_pkg::FnNotAPlusB) ? ~aluA : aluA;
    assign effB = (function_select == alu_slice_pkg::FnAPlusNotB) ? ~aluB : aluB;

    // carry, lookahead and overflow; outputs run for every function, meaningful only
    // for arithmetic, which keeps the paths free of function gating
    carry_lookahead uCarry (
        .opA(effA),
        .opB(effB),
        .carry_in(carry_in),
        .carries(carries),
        .carry_out(carry_out),
        .overflow_flag(overflow_flag),
        .group_generate_n(group_generate_n),
        .group_propagate_n(group_propagate_n)
    );

    assign isArith = (function_select == alu_slice_pkg::FnNotAPlusB) ||
                     (function_select == alu_slice_pkg::FnAPlusNotB) ||
                     (function_select == alu_slice_pkg::FnAdd);

    // function unit
    always_comb begin
        case (function_select)
            alu_slice_pkg::FnClear: aluResult = alu_slice_pkg::AllZero;
            alu_slice_pkg::FnNotAPlusB: aluResult = effA ^ effB ^ carries;
            alu_slice_pkg::FnAPlusNotB: aluResult = effA ^ effB ^ carries;
            alu_slice_pkg::FnAdd: aluResult = effA ^ effB ^ carries;
            alu_slice_pkg::FnXor: aluResult = aluA ^ aluB;
            alu_slice_pkg::FnOr: aluResult = aluA | aluB;
            alu_slice_pkg::FnAnd: aluResult = aluA & aluB;
            default: aluResult = alu_slice_pkg::AllOnes;
        endcase
    end

    assign zeroFlag = (aluResult == alu_slice_pkg::AllZero);
    assign result = output_bypass ? aluResult : resultReg;
    assign loadNow = resultLoad & loadEnable;

    // accumulator register; clear function loads zero through the normal path
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            resultReg <= alu_slice_pkg::ResultReset;
        end else if (loadNow) begin
            resultReg <= aluResult;
        end
    end

    // events are sampled when a result is loaded; carry and overflow only for arithmetic
    assign liveFlags[alu_slice_pkg::EvOverflowBit] = overflow_flag & isArith;
    assign liveFlags[alu_slice_pkg::EvCarryBit] = carry_out & isArith;
    assign liveFlags[alu_slice_pkg::EvZeroBit] = zeroFlag;
    assign eventSet = loadNow ? liveFlags : 3'h0;

    // sticky status, cleared by reading it; a same-cycle event survives the clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqStatus <= alu_slice_pkg::IrqStatusReset;
        end else begin
            irqStatus <= (statusReadClear ? 3'h0 : irqStatus) | eventSet;
        end
    end

    assign irq = |(irqStatus & irqMask);

    // write channel: address and data are taken in either order, then answered
    assign awready = ~awHeld & ~bvalid;
    assign wready = ~wHeld & ~bvalid;
    assign doWrite = awHeld & wHeld & ~bvalid;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            awHeld <= 1'b0;
            awAddrHeld <= 8'h00;
        end else if (awvalid && awready) begin
            awHeld <= 1'b1;
            awAddrHeld <= awaddr;
        end else if (doWrite) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wHeld <= 1'b0;
            wDataHeld <= 32'h00000000;
            wStrbHeld <= 4'h0;
        end else if (wvalid && wready) begin
            wHeld <= 1'b1;
            wDataHeld <= wdata;
            wStrbHeld <= wstrb;
        end else if (doWrite) begin
            wHeld <= 1'b0;
        end
    end

    // response; unmapped or read-only targets answer slave error
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp <= alu_slice_pkg::RespOkay;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            if (awAddrHeld == alu_slice_pkg::CtrlAddr ||
                awAddrHeld == alu_slice_pkg::IrqMaskAddr) begin
                bresp <= alu_slice_pkg::RespOkay;
            end else begin
                bresp <= alu_slice_pkg::RespSlvErr;
            end
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // writable fields all sit in byte lane 0
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            loadEnable <= alu_slice_pkg::CtrlLoadEnReset;
        end else if (doWrite && wStrbHeld[0] && awAddrHeld == alu_slice_pkg::CtrlAddr) begin
            loadEnable <= wDataHeld[alu_slice_pkg::CtrlLoadEnBit];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqMask <= alu_slice_pkg::IrqMaskReset;
        end else if (doWrite && wStrbHeld[0] && awAddrHeld == alu_slice_pkg::IrqMaskAddr) begin
            irqMask <= wDataHeld[2:0];
        end
    end

    // read channel: one read in flight, data registered with the valid
    assign arready = ~rvalid;
    assign doRead = arvalid & arready;
    assign statusReadClear = doRead && (araddr == alu_slice_pkg::IrqStatusAddr);

    always_comb begin
        next_rdata = 32'h00000000;
        next_rresp = alu_slice_pkg::RespOkay;
        case (araddr)
            alu_slice_pkg::CtrlAddr: next_rdata[0] = loadEnable;
            alu_slice_pkg::FlagsAddr: begin
                next_rdata[2:0] = {zeroFlag, carry_out, overflow_flag};
                next_rdata[4:3] = {group_propagate_n, group_generate_n};
            end
            alu_slice_pkg::ResultAddr: next_rdata[15:0] = resultReg;
            alu_slice_pkg::IrqStatusAddr: next_rdata[2:0] = irqStatus;
            alu_slice_pkg::IrqMaskAddr: next_rdata[2:0] = irqMask;
            default: next_rresp = alu_slice_pkg::RespSlvErr;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= alu_slice_pkg::RespOkay;
        end else if (doRead) begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- verif/alu_slice_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module alu_slice_asserts (
    input wire logic sys_clk, // clk
    input wire logic rst, // reset
    input wire logic [15:0] operandA, // a
    input wire logic [15:0] operandB, // b
    input wire logic operand_a_select, // a sel
    input wire logic operand_b_select, // b sel
    input wire logic [2:0] function_select, // fn
    input wire logic carry_in, // cin
    input wire logic resultLoad, // load
    input wire logic output_bypass, // bypass
    input wire logic [15:0] result, // f
    input wire logic zeroFlag, // zero
    input wire logic overflow_flag, // ovf
    input wire logic carry_out, // cout
    input wire logic group_generate_n, // g_n
    input wire logic group_propagate_n // p_n
);
    // plain adders stand in for the lookahead chain; bit 16 is the carry
    logic [16:0] addSum, genSum, subSum;
    logic both, addMode;
    assign addSum = {1'b0, operandA} + {1'b0, operandB} + {16'h0000, carry_in};
    assign genSum = {1'b0, operandA} + {1'b0, operandB};
    assign subSum = {1'b0, ~operandA} + {1'b0, operandB} + {16'h0000, carry_in};
    assign both = operand_a_select && operand_b_select;
    assign addMode = both && function_select == 3'h3;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // outputs are combinational, so most relations hold in the sampled cycle
    property p_zero; output_bypass |-> zeroFlag == (result == 16'h0000); endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_sum; addMode && output_bypass |-> result == addSum[15:0]; endproperty
    a_sum: assert property (p_sum) else $error("sum wrong");
    property p_cout; addMode |-> carry_out == addSum[16]; endproperty
    a_cout: assert property (p_cout) else $error("carry out wrong");
    property p_ovf; addMode |-> overflow_flag ==
        (operandA[15] == operandB[15] && addSum[15] != operandA[15]); endproperty
    a_ovf: assert property (p_ovf) else $error("overflow wrong");
    property p_prop; addMode |-> group_propagate_n == !(&(operandA | operandB)); endproperty
    a_prop: assert property (p_prop) else $error("group propagate wrong");
    property p_gen; addMode |-> group_generate_n == !genSum[16]; endproperty
    a_gen: assert property (p_gen) else $error("group generate wrong");
    property p_sub; both && function_select == 3'h1 |-> carry_out == subSum[16]; endproperty
    a_sub: assert property (p_sub) else $error("subtract carry wrong");
    property p_zsel; operand_a_select && !operand_b_select && function_select == 3'h3
        && output_bypass |-> result == operandA + {15'h0000, carry_in}; endproperty
    a_zsel: assert property (p_zsel) else $error("zero operand wrong");
    // a held register shown one cycle must be what the next sum adds
    property p_fb; (!output_bypass && !resultLoad) ##1 (output_bypass && !operand_a_select
        && !operand_b_select && function_select == 3'h3)
        |-> result == operandA + $past(result) + {15'h0000, carry_in}; endproperty
    a_fb: assert property (p_fb) else $error("feedback wrong");
endmodule
bind alu_operand_select_and_status alu_slice_asserts u_chk (.*);
`default_nettype wire

//--- verif/datapath_source.sv
`timescale 1ns/1ps
`default_nettype none
module datapath_source (
    input wire logic [3:0] cmd, // 0 random 1 preload 2 clear 3 accum 8+ fn sweep
    input wire logic [31:0] rnd, // random word
    output logic [15:0] operandA, // a
    output logic [15:0] operandB, // b
    output logic operand_a_select, // a sel
    output logic operand_b_select, // b sel
    output logic [2:0] function_select, // fn
    output logic carry_in // cin
);
    // controls follow the request; random ones reuse operand bits to save entropy
    always_comb begin
        operandA = rnd[15:0];
        operandB = rnd[31:16];
        operand_a_select = rnd[19];
        operand_b_select = rnd[20];
        function_select = rnd[23:21];
        carry_in = rnd[24];
        if (cmd == 4'h1 || cmd == 4'h3) begin
            operand_a_select = cmd == 4'h1;
            operand_b_select = 1'b0;
            function_select = alu_slice_pkg::FnAdd;
            carry_in = 1'b0;
        end else if (cmd == 4'h2) begin
            function_select = alu_slice_pkg::FnClear;
        end else if (cmd[3]) begin
            operand_a_select = 1'b1;
            operand_b_select = 1'b1;
            function_select = cmd[2:0];
        end
    end
endmodule
`default_nettype wire

//--- verif/alu_operand_select_and_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module alu_operand_select_and_status_tb_top;
    logic sys_clk = 1'b0, rst = 1'b1, resultLoad = 1'b0, output_bypass = 1'b0, loadEn = 1'b1;
    logic [3:0] cmd = 4'h0;
    logic [31:0] rnd = 32'h0, seed = 32'h5199, rd;
    logic [15:0] operandA, operandB, result, accReg = 16'h0000;
    logic operand_a_select, operand_b_select, carry_in, zeroFlag, overflow_flag, carry_out;
    logic [2:0] function_select;
    logic group_generate_n, group_propagate_n, irq, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp;
    logic [31:0] corner [5] = '{32'h0, 32'hFFFFFFFF, 32'h00017FFF, 32'h80008000, 32'h7FFF8001};
    int bad_count = 0, check_count = 0, cycles = 0;
    alu_operand_select_and_status uut (.*);
    datapath_source src (.*);
    initial forever #4 sys_clk = ~sys_clk;
    // hang guard: the run needs about 450 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [16:0] alu_f(input logic [15:0] a, b, input logic [2:0] f,
                                          input logic c);
        case (f)
            3'h0: return 17'h00000;
            3'h1: return {1'b0, ~a} + {1'b0, b} + 17'(c);
            3'h2: return {1'b0, a} + {1'b0, ~b} + 17'(c);
            3'h3: return {1'b0, a} + {1'b0, b} + 17'(c);
            3'h4: return {1'b0, a ^ b};
            3'h5: return {1'b0, a | b};
            3'h6: return {1'b0, a & b};
            default: return 17'h0FFFF;
        endcase
    endfunction
    // write: address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic awGo, wGo, hit;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        resultLoad <= 1'b0;
        do begin
            @(negedge sys_clk);
            awGo = awvalid && awready;
            wGo = wvalid && wready;
            hit = bvalid;
            if (hit) check(32'(bresp), 32'(er));
            @(posedge sys_clk);
            if (awGo) awvalid <= 1'b0;
            if (wGo) wvalid <= 1'b0;
        end while (!hit);
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        logic arGo, hit;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        resultLoad <= 1'b0;
        do begin
            @(negedge sys_clk);
            arGo = arvalid && arready;
            hit = rvalid;
            if (hit) check(32'(rresp), 32'(er));
            d = rdata;
            @(posedge sys_clk);
            if (arGo) arvalid <= 1'b0;
        end while (!hit);
        rready <= 1'b0;
    endtask
    // one datapath cycle, checked against a model of the selected operands
    task automatic step(input logic [3:0] c, input logic [31:0] r, input logic ld, byp);
        logic [16:0] s;
        logic [15:0] x, y;
        @(posedge sys_clk);
        cmd <= c;
        rnd <= r;
        resultLoad <= ld;
        output_bypass <= byp;
        @(negedge sys_clk);
        x = (operand_b_select && !operand_a_select) ? 16'h0000 : operandA;
        y = operand_b_select ? operandB : (operand_a_select ? 16'h0000 : accReg);
        s = alu_f(x, y, function_select, carry_in);
        check(32'(result), 32'(byp ? s[15:0] : accReg));
        check(32'(zeroFlag), 32'(s[15:0] == 16'h0000));
        if (function_select inside {3'h1, 3'h2, 3'h3}) begin
            x = function_select == 3'h1 ? ~x : x;
            y = function_select == 3'h2 ? ~y : y;
            check(32'(carry_out), 32'(s[16]));
            check(32'(overflow_flag), 32'(x[15] == y[15] && s[15] != x[15]));
            check(32'(group_propagate_n), 32'(!(&(x | y))));
            // group generate is the carry out of the sum with no carry in
            check(32'(group_generate_n), 32'(!((17'(x) + 17'(y)) >> 16)));
        end
        if (ld && loadEn) accReg = s[15:0];
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        axi_read(8'h00, rd, 2'h0);
        check(rd, 32'h1);
        axi_read(8'h10, rd, 2'h0);
        check(rd, 32'h0);
        axi_read(8'h14, rd, 2'h2);
        check(rd, 32'h0);
        axi_write(8'h04, 32'h1F, 2'h2);
        // every function code over awkward operand pairs, then a random mix
        for (int i = 0; i < 5; i++) for (int f = 0; f < 8; f++) step(4'(8 + f), corner[i], 0, 1);
        repeat (300) begin
            seed = xs(seed);
            step(4'h0, seed, seed[25], seed[26]);
        end
        // accumulate: preload, then alternate a held view and an add
        seed = xs(seed);
        step(4'h1, seed, 1'b1, 1'b1);
        repeat (20) begin
            seed = xs(seed);
            step(4'h3, seed, 1'b0, 1'b0);
            step(4'h3, seed, 1'b1, 1'b1);
        end
        step(4'h2, seed, 1'b1, 1'b1);
        step(4'h3, seed, 1'b0, 1'b0);
        axi_read(8'h08, rd, 2'h0);
        check(rd, 32'(accReg));
        // loads refused while the enable bit is clear
        axi_write(8'h00, 32'h0, 2'h0);
        loadEn = 1'b0;
        repeat (3) step(4'h0, xs(seed), 1'b1, 1'b0);
        axi_write(8'h00, 32'h1, 2'h0);
        loadEn = 1'b1;
        // zero event raises irq when unmasked, read clears it; masked stays low
        axi_read(8'h0C, rd, 2'h0);
        axi_write(8'h10, 32'h4, 2'h0);
        step(4'h2, seed, 1'b1, 1'b1);
        @(negedge sys_clk);
        check(32'(irq), 32'h1);
        axi_read(8'h0C, rd, 2'h0);
        check(rd, 32'h4);
        @(negedge sys_clk);
        check(32'(irq), 32'h0);
        axi_write(8'h10, 32'h0, 2'h0);
        step(4'h2, seed, 1'b1, 1'b1);
        @(negedge sys_clk);
        check(32'(irq), 32'h0);
        axi_read(8'h0C, rd, 2'h0);
        check(rd, 32'h4);
        wrap_up();
    end
endmodule
`default_nettype wire
